//--- dv/bcc_regs_test.sv
// self-checking bench for the converter control register bank
`timescale 1ns/1ns
module bcc_regs_test;
    localparam logic [11:0] CTRL_ADR = 12'h25C;
    localparam logic [11:0] CFG_ADR = 12'h258;
    localparam logic [11:0] BAD_ADR = 12'h100;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, sws, lock, adc_inv, track, sar, cinv, ilim, slp, src, tick, phase;
    logic [1:0] mpw, div;
    logic [2:0] mpw_cyc, output_voltage_select;
    logic [5:0] dv;
    logic [7:0] ctrl_m, cfg_m;
    logic lock_old, track_old;
    logic [31:0] rd, v;
    int errors = 0;
    int samples_checked = 0;
    int seed = 74;
    int volt_dv[8] = '{18, 19, 20, 21, 24, 27, 30, 33};
    int cyc_of[4] = '{0, 1, 1, 2};

    bcc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .min_pulse_width_o(mpw),
        .min_pulse_cycles_o(mpw_cyc), .switch_size_select_o(sws), .adc_lockstep_o(lock),
        .adc_clk_invert_o(adc_inv), .adc_track_o(track), .adc_sar_tick_o(sar),
        .output_voltage_select_o(output_voltage_select), .target_decivolts_o(dv),
        .converter_clock_divider_o(div), .converter_clock_invert_o(cinv),
        .peak_current_limit_o(ilim), .sleep_output_float_o(slp),
        .converter_clock_source_o(src), .converter_clock_tick_o(tick),
        .converter_clock_phase_o(phase));

    // older silicon twin: lockstep must stay dormant
    bcc_regs #(.SILICON_REV(2)) uut_old (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(), .wb_ack_o(), .min_pulse_width_o(),
        .min_pulse_cycles_o(), .switch_size_select_o(), .adc_lockstep_o(lock_old),
        .adc_clk_invert_o(), .adc_track_o(track_old), .adc_sar_tick_o(),
        .output_voltage_select_o(), .target_decivolts_o(), .converter_clock_divider_o(),
        .converter_clock_invert_o(), .peak_current_limit_o(), .sleep_output_float_o(),
        .converter_clock_source_o(), .converter_clock_tick_o(), .converter_clock_phase_o());

    always #25 clk_i = ~clk_i;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task test_done;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // one classic cycle; the slave answers after one cycle but we never rely on it
    task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] d,
                      input logic s0, output logic [31:0] rdata);
        int n;
        logic [31:0] r;
        r = $random(seed);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {r[23:0], d};
        wb_sel_i <= {3'h0, s0};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            errors++;
            $display("CHECK FAILED wb_ack_o expected 1 seen %b", wb_ack_o);
            test_done();
        end
        rdata = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask : wb

    task automatic wr(input logic [11:0] adr, input logic [7:0] d, input logic s0);
        wb(1'h1, adr, d, s0, rd);
        if (s0 && adr == CTRL_ADR) ctrl_m = d & bcc_pkg::BCC_CTRL_WMASK;
        if (s0 && adr == CFG_ADR) cfg_m = d & bcc_pkg::BCC_CFG_WMASK;
    endtask : wr

    // lockstep follows the control register one cycle late, so settle first
    task automatic chk_out;
        int t, s, p, k, p_exp;
        repeat (3) @(posedge clk_i);
        chk("old silicon adc_lockstep_o", 32'h0, lock_old);
        chk("old silicon adc_track_o", 32'h0, track_old);
        chk("min_pulse_width_o", ctrl_m[7:6], mpw);
        chk("min_pulse_cycles_o", cyc_of[ctrl_m[7:6]], mpw_cyc);
        chk("switch_size_select_o", ctrl_m[5], sws);
        chk("adc_lockstep_o", ctrl_m[3], lock);
        chk("adc_clk_invert_o", ctrl_m[3] & ~cfg_m[4], adc_inv);
        chk("output_voltage_select_o", ctrl_m[2:0], output_voltage_select);
        chk("target_decivolts_o", volt_dv[ctrl_m[2:0]], dv);
        chk("converter_clock_divider_o", cfg_m[6:5], div);
        chk("converter_clock_invert_o", cfg_m[3], cinv);
        chk("converter_clock_source_o", cfg_m[0], src);
        chk("peak_current_limit_o", cfg_m[2], ilim);
        chk("sleep_output_float_o", cfg_m[1], slp);
        wb(1'h0, CTRL_ADR, 8'h00, 1'h1, rd);
        chk("converter_control", {24'h0, ctrl_m}, rd);
        wb(1'h0, CFG_ADR, 8'h00, 1'h1, rd);
        chk("converter_configuration", {24'h0, cfg_m}, rd);
        // window of 64 cycles holds a whole number of divided periods
        t = 0;
        s = 0;
        p = 0;
        k = 0;
        repeat (64) begin
            @(posedge clk_i);
            t += (tick === 1'h1);
            s += (sar === 1'h1);
            p += (phase === 1'h1);
            k += (track === 1'h1);
        end
        // phase is high half of each divided period; undivided it is constant
        p_exp = !cfg_m[0] ? 0 : cfg_m[6:5] != 2'h0 ? 32 : cfg_m[3] ? 0 : 64;
        chk("converter_clock_phase_o", p_exp, p);
        chk("adc_track_o", ctrl_m[3] ? 64 - p_exp : 0, k);
        chk("converter_clock_tick_o", cfg_m[0] ? 64 >> cfg_m[6:5] : 0, t);
        chk("adc_sar_tick_o", (cfg_m[0] & ctrl_m[3]) ? 64 >> cfg_m[6:5] : 0, s);
    endtask : chk_out

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        ctrl_m = 8'h21;
        cfg_m = 8'h00;
        chk_out();
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            // lockstep on odd passes; adc divider field outside this bank, taken as zero
            wr(CTRL_ADR, {i[1:0], v[5:4], i[0], i[2:0]}, 1'h1);
            wr(CFG_ADR, {v[15], i[1:0], v[12:9], i[2:0] != 3'h2}, 1'h1);
            chk_out();
        end
        // refused writes: byte lane off and unmapped address
        wr(CTRL_ADR, 8'h00, 1'h0);
        wr(BAD_ADR, 8'hFF, 1'h1);
        wb(1'h0, BAD_ADR, 8'h00, 1'h1, rd);
        chk("unmapped read", 32'h00000000, rd);
        chk_out();
        // second reset in mid-run
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        ctrl_m = 8'h21;
        cfg_m = 8'h00;
        chk_out();
        test_done();
    end
endmodule : bcc_regs_test

//--- hdl/bcc_clk_div.sv
// system clock divider producing converter clock ticks and phase
`timescale 1ns/1ns
module bcc_clk_div (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic restart_i,
    input wire logic [1:0] div_code_i,
    input wire logic invert_i,
    output logic tick_o,
    output logic phase_o
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic [2:0] last_w;
    logic [2:0] half_w;
    logic wrap_w;
    logic tick_ff;
    logic phase_ff;

    // divide by 1, 2, 4, 8
    assign last_w = 3'((4'h1 << div_code_i) - 4'h1);
    assign half_w = 3'((4'h1 << div_code_i) >> 1);
    assign wrap_w = (cnt_ff == last_w);
    // restart on reconfiguration so a new ratio starts from a clean period
    assign nxt_cnt = (!enable_i || restart_i || wrap_w) ? 3'h0 : 3'(cnt_ff + 3'h1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 3'h0;
            tick_ff <= 1'b0;
            phase_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= enable_i && !restart_i && wrap_w;
            // high in first half of the period; inversion flips it
            phase_ff <= enable_i && ((nxt_cnt < half_w || last_w == 3'h0) ^ invert_i);
        end
    end

    assign tick_o = tick_ff;
    assign phase_o = phase_ff;
endmodule : bcc_clk_div

//--- hdl/bcc_pkg.sv
// constants shared by the boost converter control register bank
package bcc_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] BCC_CTRL_IDX = 10'h097;
    localparam logic [9:0] BCC_CFG_IDX = 10'h096;
    localparam logic [7:0] BCC_CTRL_RST = 8'h21;
    localparam logic [7:0] BCC_CFG_RST = 8'h00;
    // converter_control fields
    localparam int BCC_MPW_LSB = 6;
    localparam int BCC_SWS_BIT = 5;
    localparam int BCC_CTRL_RSV_BIT = 4;
    localparam int BCC_LOCK_BIT = 3;
    localparam int BCC_OUTPUT_VOLTAGE_SELECT_LSB = 0;
    // converter_configuration fields
    localparam int BCC_CFG_RSV_BIT = 7;
    localparam int BCC_DIV_LSB = 5;
    localparam int BCC_ADCINV_BIT = 4;
    localparam int BCC_CONVERTER_CLOCK_INVERT_BIT = 3;
    localparam int BCC_ILIM_BIT = 2;
    localparam int BCC_SLP_BIT = 1;
    localparam int BCC_SRC_BIT = 0;
    // writable bits; reserved bits are held at zero
    localparam logic [7:0] BCC_CTRL_WMASK = 8'hEF;
    localparam logic [7:0] BCC_CFG_WMASK = 8'h7F;
    // minimum pulse widths and their cycle counts, rounded up
    localparam int BCC_CLK_PERIOD_NS = 50;
    localparam int BCC_MPW1_NS = 20;
    localparam int BCC_MPW2_NS = 40;
    localparam int BCC_MPW3_NS = 80;
    localparam int BCC_MPW1_CYC = (BCC_MPW1_NS + BCC_CLK_PERIOD_NS - 1) / BCC_CLK_PERIOD_NS;
    localparam int BCC_MPW2_CYC = (BCC_MPW2_NS + BCC_CLK_PERIOD_NS - 1) / BCC_CLK_PERIOD_NS;
    localparam int BCC_MPW3_CYC = (BCC_MPW3_NS + BCC_CLK_PERIOD_NS - 1) / BCC_CLK_PERIOD_NS;
    // target output voltage in tenths of a volt, per select code
    localparam logic [5:0] BCC_VOLT_DV [8] = '{6'h12, 6'h13, 6'h14, 6'h15,
                                               6'h18, 6'h1B, 6'h1E, 6'h21};
    // first silicon revision with lockstep behaviour
    localparam int BCC_REV_LOCKSTEP = 3;
endpackage : bcc_pkg

//--- hdl/bcc_regs.sv
// boost converter control and configuration registers on a Wishbone slave
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
module bcc_regs #(
    parameter int ADDR_W = 12,
    parameter int SILICON_REV = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [1:0] min_pulse_width_o,
    output logic [2:0] min_pulse_cycles_o,
    output logic switch_size_select_o,
    output logic adc_lockstep_o,
    output logic adc_clk_invert_o,
    output logic adc_track_o,
    output logic adc_sar_tick_o,
    output logic [2:0] output_voltage_select_o,
    output logic [5:0] target_decivolts_o,
    output logic [1:0] converter_clock_divider_o,
    output logic converter_clock_invert_o,
    output logic peak_current_limit_o,
    output logic sleep_output_float_o,
    output logic converter_clock_source_o,
    output logic converter_clock_tick_o,
    output logic converter_clock_phase_o
);
    if (ADDR_W < 12) begin : g_chk_addr
        $error("bcc_regs: ADDR_W must be at least 12");
    end
    if (SILICON_REV < 0) begin : g_chk_rev
        $error("bcc_regs: SILICON_REV must not be negative");
    end

    localparam logic REV_HAS_LOCK = (SILICON_REV >= bcc_pkg::BCC_REV_LOCKSTEP);

    logic [7:0] ctrl_ff;
    logic [7:0] cfg_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [2:0] mpw_cyc_ff;
    logic [5:0] volt_ff;
    logic lock_ff;
    logic adc_inv_ff;
    logic track_ff;
    logic sar_tick_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] nxt_cfg;
    logic [31:0] nxt_rdat;
    logic [2:0] nxt_mpw_cyc;
    logic div_tick_w;
    logic div_phase_w;

    // bus decode
    wire req_w = wb_cyc_i && wb_stb_i;
    wire take_w = req_w && ack_ff;
    wire [ADDR_W-1:0] ctrl_addr_w = ADDR_W'({bcc_pkg::BCC_CTRL_IDX, 2'b00});
    wire [ADDR_W-1:0] cfg_addr_w = ADDR_W'({bcc_pkg::BCC_CFG_IDX, 2'b00});
    wire hit_ctrl_w = (wb_adr_i == ctrl_addr_w);
    wire hit_cfg_w = (wb_adr_i == cfg_addr_w);
    wire lane0_wr_w = take_w && wb_we_i && wb_sel_i[0];
    wire wr_ctrl_w = lane0_wr_w && hit_ctrl_w;
    wire wr_cfg_w = lane0_wr_w && hit_cfg_w;

    // reserved bits masked so they always read 0
    assign nxt_ctrl = wr_ctrl_w ? (wb_dat_i[7:0] & bcc_pkg::BCC_CTRL_WMASK) : ctrl_ff;
    assign nxt_cfg = wr_cfg_w ? (wb_dat_i[7:0] & bcc_pkg::BCC_CFG_WMASK) : cfg_ff;
    // unmapped addresses answer with zero
    assign nxt_rdat = hit_ctrl_w ? {24'h000000, ctrl_ff} :
                      hit_cfg_w ? {24'h000000, cfg_ff} : 32'h00000000;

    wire [1:0] nxt_mpw_w = nxt_ctrl[bcc_pkg::BCC_MPW_LSB +: 2];
    always_comb begin
        case (nxt_mpw_w)
            2'h1: nxt_mpw_cyc = 3'(bcc_pkg::BCC_MPW1_CYC);
            2'h2: nxt_mpw_cyc = 3'(bcc_pkg::BCC_MPW2_CYC);
            2'h3: nxt_mpw_cyc = 3'(bcc_pkg::BCC_MPW3_CYC);
            default: nxt_mpw_cyc = 3'h0;
        endcase
    end

    // ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end else begin
            ack_ff <= req_w && !ack_ff;
            rdat_ff <= (req_w && !ack_ff) ? nxt_rdat : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= bcc_pkg::BCC_CTRL_RST;
            cfg_ff <= bcc_pkg::BCC_CFG_RST;
            mpw_cyc_ff <= 3'h0;
            volt_ff <= bcc_pkg::BCC_VOLT_DV[1];
        end else begin
            ctrl_ff <= nxt_ctrl;
            cfg_ff <= nxt_cfg;
            mpw_cyc_ff <= nxt_mpw_cyc;
            volt_ff <= bcc_pkg::BCC_VOLT_DV[nxt_ctrl[bcc_pkg::BCC_OUTPUT_VOLTAGE_SELECT_LSB +: 3]];
        end
    end

    // divider runs only on the system clock source; local oscillator ignores it
    bcc_clk_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(cfg_ff[bcc_pkg::BCC_SRC_BIT]),
        .restart_i(wr_cfg_w),
        .div_code_i(cfg_ff[bcc_pkg::BCC_DIV_LSB +: 2]),
        .invert_i(cfg_ff[bcc_pkg::BCC_CONVERTER_CLOCK_INVERT_BIT]),
        .tick_o(div_tick_w),
        .phase_o(div_phase_w)
    );

    // older silicon has no lockstep; the bit is stored but has no effect
    wire lock_req_w = ctrl_ff[bcc_pkg::BCC_LOCK_BIT] && REV_HAS_LOCK;
    // adc_clk invert bit is active low and only matters in lockstep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_ff <= 1'b0;
            adc_inv_ff <= 1'b0;
            track_ff <= 1'b0;
            sar_tick_ff <= 1'b0;
        end else begin
            lock_ff <= lock_req_w;
            adc_inv_ff <= lock_req_w && !cfg_ff[bcc_pkg::BCC_ADCINV_BIT];
            // quiet interval taken as the low half of the converter period
            track_ff <= lock_ff && !div_phase_w;
            sar_tick_ff <= lock_ff && div_tick_w;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign min_pulse_width_o = ctrl_ff[bcc_pkg::BCC_MPW_LSB +: 2];
    assign min_pulse_cycles_o = mpw_cyc_ff;
    assign switch_size_select_o = ctrl_ff[bcc_pkg::BCC_SWS_BIT];
    assign adc_lockstep_o = lock_ff;
    assign adc_clk_invert_o = adc_inv_ff;
    assign adc_track_o = track_ff;
    assign adc_sar_tick_o = sar_tick_ff;
    assign output_voltage_select_o = ctrl_ff[bcc_pkg::BCC_OUTPUT_VOLTAGE_SELECT_LSB +: 3];
    assign target_decivolts_o = volt_ff;
    assign converter_clock_divider_o = cfg_ff[bcc_pkg::BCC_DIV_LSB +: 2];
    assign converter_clock_invert_o = cfg_ff[bcc_pkg::BCC_CONVERTER_CLOCK_INVERT_BIT];
    assign peak_current_limit_o = cfg_ff[bcc_pkg::BCC_ILIM_BIT];
    assign sleep_output_float_o = cfg_ff[bcc_pkg::BCC_SLP_BIT];
    assign converter_clock_source_o = cfg_ff[bcc_pkg::BCC_SRC_BIT];
    assign converter_clock_tick_o = div_tick_w;
    assign converter_clock_phase_o = div_phase_w;

    // checks
    sequence s_wr_ctrl;
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && hit_ctrl_w;
    endsequence

    sequence s_wr_cfg;
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && hit_cfg_w;
    endsequence

    AST_RESET_VALUES: assert property (@(posedge clk_i)
        $fell(rst_i) |-> switch_size_select_o && output_voltage_select_o == 3'h1
            && min_pulse_width_o == 2'h0 && !adc_lockstep_o && target_decivolts_o == 6'h13)
        else $error("control register reset value wrong");

    AST_WRITE_CTRL: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wr_ctrl |=> output_voltage_select_o == $past(wb_dat_i[2:0])
            && min_pulse_width_o == $past(wb_dat_i[7:6]))
        else $error("control write not applied");

    AST_SWITCH: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wr_ctrl |=> switch_size_select_o == $past(wb_dat_i[5]))
        else $error("switch size select not applied");

    AST_MIN_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        (min_pulse_width_o == 2'h0 |-> min_pulse_cycles_o == 3'h0)
        and (min_pulse_width_o == 2'h3 |-> min_pulse_cycles_o == 3'h2)
        and (min_pulse_width_o == 2'h1 |-> min_pulse_cycles_o == 3'h1))
        else $error("minimum pulse cycles mismatch");

    AST_VOLTAGE: assert property (@(posedge clk_i) disable iff (rst_i)
        (output_voltage_select_o == 3'h0 |-> target_decivolts_o == 6'h12)
        and (output_voltage_select_o == 3'h7 |-> target_decivolts_o == 6'h21)
        and (output_voltage_select_o == 3'h4 |-> target_decivolts_o == 6'h18))
        else $error("target voltage mismatch");

    AST_LOCK_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(adc_lockstep_o) |-> !adc_sar_tick_o && !adc_track_o)
        else $error("adc lockstep activity without lockstep");

    AST_LOCK_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
        adc_lockstep_o && converter_clock_tick_o |=> adc_sar_tick_o)
        else $error("sar tick not following converter tick");

    AST_OSC_IGNORES_DIV: assert property (@(posedge clk_i) disable iff (rst_i)
        !converter_clock_source_o |=> !converter_clock_tick_o)
        else $error("divider ticks on local oscillator");

    AST_DIV_SPACING: assert property (@(posedge clk_i) disable iff (rst_i)
        converter_clock_tick_o && converter_clock_divider_o != 2'h0
            && $stable(converter_clock_divider_o) |=> !converter_clock_tick_o)
        else $error("divided ticks too close");

    AST_WRITE_CFG: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wr_cfg |=> sleep_output_float_o == $past(wb_dat_i[1])
            && peak_current_limit_o == $past(wb_dat_i[2]))
        else $error("configuration write not applied");

    AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000 && !(hit_cfg_w && wb_dat_o[7])
            && !(hit_ctrl_w && wb_dat_o[4]))
        else $error("reserved read bits not zero");

    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
endmodule : bcc_regs
